// ### rtl/pst_pkg.sv
/*
 * Shared constants and types of the carrier-synchronised conversion and
 * control-task trigger block.
 * Assumes one clock domain; analog handshakes arrive asynchronously.
 */
package pst_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NGEN  = 2;   // Carrier generators
  localparam int NCONV = 2;   // Converters
  localparam int GSW   = 1;   // Generator select width
  localparam int CSW   = 1;   // Converter select width
  localparam int NCH   = 4;   // Channel slots per converter
  localparam int CHW   = 3;   // Analog channel index width
  localparam int NW    = 3;   // Channel count width
  localparam int DW    = 12;  // Sample width
  localparam int CW    = 16;  // Carrier counter width
  localparam int RW    = 4;   // Repetition count width
  localparam int TW    = 16;  // Task timer width

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int EV_UF = 0;   // Underflow bit of an edge mask
  localparam int EV_OV = 1;   // Overflow bit of an edge mask
  localparam logic [CW-1:0] CNT_RST = 16'h0000;
  localparam logic [CW-1:0] PER_MIN = 16'h0002;

  // ----------------------------------------------------------------------
  // Modes, states, converter and handshake records
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PST_SRC_TIMER   = 2'h0,
    PST_SRC_CARRIER = 2'h1,
    PST_SRC_EOC     = 2'h2
  } pst_src_t;

  typedef enum logic [2:0] {
    PST_SQ_IDLE = 3'h1,
    PST_SQ_REQ  = 3'h2,
    PST_SQ_REL  = 3'h4
  } pst_sq_t;

  typedef struct packed {
    logic [GSW-1:0]     gen;     // Carrier that starts the run
    logic [1:0]         edges;   // Extremes that start the run
    logic [NW-1:0]      n_chans; // Channels in the run
    logic [NCH*CHW-1:0] list;    // Channel order, slot 0 first
  } pst_conv_cfg_t;

  typedef struct packed {
    logic           req;
    logic [CHW-1:0] chan;
  } pst_smp_req_t;

  typedef struct packed {
    logic          done;
    logic [DW-1:0] data;
  } pst_smp_rsp_t;

endpackage : pst_pkg

// ### rtl/pst_conv_seq.sv
/*
 * One converter's sequencer: on a start it samples the configured
 * channels in list order and raises end-of-conversion after the last.
 * Assumes the response is already synchronised to clk_i and that the
 * analog side holds data while done is high (four-phase handshake).
 */
module pst_conv_seq
  import pst_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  nrst_i,
  input  wire logic                  soc_i,
  input  wire pst_conv_cfg_t         cfg_i,
  input  wire pst_smp_rsp_t          rsp_i,
  output pst_smp_req_t               req_o,
  output logic [NCH*DW-1:0]          res_o,
  output logic                       busy_o,
  output logic                       eoc_o,
  output logic                       ovr_o
);

  typedef struct packed {
    pst_sq_t           st;
    logic [NW-1:0]     idx;
    pst_smp_req_t      req;
    logic [NCH*DW-1:0] res;
    logic              eoc;
    logic              ovr;
  } pst_seq_st_t;

  pst_seq_st_t q;
  pst_seq_st_t d;
  logic        last;

  // ----------------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------------
  assign last = (q.idx + NW'(1) >= cfg_i.n_chans) ||
                (q.idx == NW'(NCH - 1));

  // Next state of the run
  always_comb begin
    d     = q;
    d.eoc = 1'b0;
    d.ovr = 1'b0;
    case (q.st)
      PST_SQ_IDLE: begin
        if (soc_i) begin
          d.st       = PST_SQ_REQ;                  // R1
          d.idx      = '0;
          d.req.req  = 1'b1;
          d.req.chan = cfg_i.list[CHW-1:0];         // R15
        end
      end
      PST_SQ_REQ: begin
        if (rsp_i.done) begin
          d.res[q.idx*DW +: DW] = rsp_i.data;      // R2
          d.req.req = 1'b0;
          d.st      = PST_SQ_REL;
        end
      end
      PST_SQ_REL: begin
        if (!rsp_i.done) begin
          if (last) begin
            d.st  = PST_SQ_IDLE;
            d.eoc = 1'b1;                           // R3
          end else begin
            d.idx      = q.idx + NW'(1);            // R15
            d.req.req  = 1'b1;
            d.req.chan = cfg_i.list[(q.idx + NW'(1))*CHW +: CHW];
            d.st       = PST_SQ_REQ;
          end
        end
      end
      default: d.st = PST_SQ_IDLE;
    endcase
    // Start during a run is dropped and reported
    if (soc_i && q.st != PST_SQ_IDLE) begin
      d.ovr = 1'b1;                                 // R17
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '{st: PST_SQ_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign req_o  = q.req;
  assign res_o  = q.res;
  assign busy_o = (q.st != PST_SQ_IDLE);
  assign eoc_o  = q.eoc;
  assign ovr_o  = q.ovr;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_start;
    soc_i && q.st == PST_SQ_IDLE;
  endsequence

  sequence s_first_req;
    req_o.req && req_o.chan == $past(cfg_i.list[CHW-1:0]);
  endsequence

  a_first_chan_req: assert property (s_start |=> s_first_req) // R1
    else $error("run did not request its first channel");
  a_eoc_after_last: assert property (
    eoc_o |-> $past(q.st == PST_SQ_REL && last) && !busy_o) // R2
    else $error("end of conversion before last channel");
  a_soc_busy_drop: assert property (
    (soc_i && busy_o) |=> ovr_o && q.idx >= $past(q.idx)) // R17
    else $error("start during a run was not dropped");

endmodule : pst_conv_seq

// ### rtl/pst_trig_top.sv
/*
 * Carrier-synchronised conversion and control-task trigger block:
 * up-down carriers, shadowed duty values, per-converter start selection,
 * conversion sequencers and the control-task trigger with overrun guard.
 * Assumes configuration inputs are quasi-static and the controller
 * pulses task_done_i on clk_i when the task finishes.
 */
// Contract
// R1: A carrier extreme starts the linked converter at its first channel.
// R2: Channels convert one after another; run ends after last result.
// R3: End-of-conversion after all results fires the control-task trigger.
// R4: Task trigger selectable per extreme, twice per carrier period.
// R5: Task trigger may fire less often than the carrier.
// R6: Duty moves to active compare only at a carrier extreme.
// R7: Controller writes duty when done; applied at next extreme after.
// R8: With conversion-started tasks, duty applies at extreme after all.
// R9: Each converter picks its own carrier and extreme as start source.
// R10: Phase-shifted: second converter's completion triggers task.
// R11: Every task trigger starts the base task at once; code starts it only if no task is busy and no task overrun is flagged.
// R12: Trigger during a running task flags overrun and halts.
// R13: Underflow at counter minimum, overflow at counter maximum.
// R14: Repetition count sets extremes per task trigger.
// R15: Channels convert in configured list order.
// R16: Shadow duty copied to active compare in the extreme's cycle.
// R17: Start during a run is ignored and sets a sticky overrun flag.
module pst_trig_top
  import pst_pkg::*;
#(
  parameter int NG = NGEN,
  parameter int NC = NCONV
) (
  input  wire logic                         clk_i,
  input  wire logic                         nrst_i,
  input  wire logic [NG-1:0][CW-1:0]        carrier_period_i,
  input  wire logic [NG-1:0][1:0]           upd_mask_i,
  input  wire logic [NG-1:0]                duty_wr_i,
  input  wire logic [NG-1:0][CW-1:0]        duty_i,
  input  wire pst_conv_cfg_t [NC-1:0]       conv_cfg_i,
  input  wire pst_smp_rsp_t [NC-1:0]        smp_rsp_i,
  input  wire logic [NC-1:0]                soc_ovr_clr_i,
  input  wire pst_src_t                     task_src_i,
  input  wire logic [GSW-1:0]               task_gen_i,
  input  wire logic [1:0]                   task_edges_i,
  input  wire logic [RW-1:0]                task_rep_i,
  input  wire logic [CSW-1:0]               task_conv_i,
  input  wire logic [TW-1:0]                tmr_period_i,
  input  wire logic                         task_done_i,
  output logic [NG-1:0]                     pwm_o,
  output logic [NG-1:0]                     uf_o,
  output logic [NG-1:0]                     ov_o,
  output pst_smp_req_t [NC-1:0]             smp_req_o,
  output logic [NC-1:0][NCH*DW-1:0]         result_o,
  output logic [NC-1:0]                     eoc_o,
  output logic [NC-1:0]                     soc_ovr_o,
  output logic                              task_trig_o,
  output logic                              task_busy_o,
  output logic                              task_ovr_o
);

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  if (NG < 1 || NG > 2**GSW || NC < 1 || NC > 2**CSW) begin : g_bad
    $error("pst_trig_top: NG or NC outside select range");
  end

  typedef struct packed {
    logic [NG-1:0][CW-1:0] cnt;
    logic [NG-1:0]         down;
    logic [NG-1:0]         uf;
    logic [NG-1:0]         ov;
    logic [NG-1:0][CW-1:0] shadow;
    logic [NG-1:0][CW-1:0] cmp;
    logic [NG-1:0]         pend;
    logic [NG-1:0]         pwm;
    pst_smp_rsp_t [NC-1:0] s1;
    pst_smp_rsp_t [NC-1:0] s2;
    logic [RW-1:0]         rep;
    logic [TW-1:0]         tmr;
    logic                  trig;
    logic                  busy;
    logic                  ovr;
    logic [NC-1:0]         soc_ovr;
  } pst_top_st_t;

  pst_top_st_t   q;
  pst_top_st_t   d;
  logic [NC-1:0] soc;
  logic [NC-1:0] seq_eoc;
  logic [NC-1:0] seq_ovr;
  logic          ev_sel;
  logic          fire;

  // ----------------------------------------------------------------------
  // Converter sequencers
  // ----------------------------------------------------------------------
  for (genvar c = 0; c < NC; c++) begin : g_conv
    // Start from the chosen carrier's chosen extremes
    assign soc[c] =
      (q.uf[conv_cfg_i[c].gen] & conv_cfg_i[c].edges[EV_UF]) |
      (q.ov[conv_cfg_i[c].gen] & conv_cfg_i[c].edges[EV_OV]); // R9 R1

    pst_conv_seq u_seq (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .soc_i  (soc[c]),
      .cfg_i  (conv_cfg_i[c]),
      .rsp_i  (q.s2[c]),
      .req_o  (smp_req_o[c]),
      .res_o  (result_o[c]),
      .busy_o (),
      .eoc_o  (seq_eoc[c]),
      .ovr_o  (seq_ovr[c])
    );
  end

  // Task carrier event from the selected generator
  assign ev_sel = (q.uf[task_gen_i] & task_edges_i[EV_UF]) |
                  (q.ov[task_gen_i] & task_edges_i[EV_OV]); // R4

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    d      = q;
    d.uf   = '0;
    d.ov   = '0;
    d.trig = 1'b0;
    fire   = 1'b0;
    // Two-stage capture of the analog handshake
    d.s1 = smp_rsp_i;
    d.s2 = q.s1;

    // Up-down carriers, shadow transfer, modulator
    for (int g = 0; g < NG; g++) begin
      if (carrier_period_i[g] < PER_MIN) begin
        d.cnt[g]  = CNT_RST;
        d.down[g] = 1'b0;
      end else if (!q.down[g]) begin
        if (q.cnt[g] >= carrier_period_i[g] - CW'(1)) begin
          d.cnt[g]  = carrier_period_i[g];
          d.down[g] = 1'b1;
          d.ov[g]   = 1'b1;                         // R13
        end else begin
          d.cnt[g] = q.cnt[g] + CW'(1);
        end
      end else begin
        if (q.cnt[g] <= CW'(1)) begin
          d.cnt[g]  = CNT_RST;
          d.down[g] = 1'b0;
          d.uf[g]   = 1'b1;                         // R13
        end else begin
          d.cnt[g] = q.cnt[g] - CW'(1);
        end
      end
      // Copy shadow only at a selected extreme
      if (q.pend[g] && ((d.uf[g] && upd_mask_i[g][EV_UF]) ||
                        (d.ov[g] && upd_mask_i[g][EV_OV]))) begin
        d.cmp[g]  = q.shadow[g];                    // R6 R16 R8
        d.pend[g] = 1'b0;
      end
      // Write after the extreme check: waits for the next one
      if (duty_wr_i[g]) begin
        d.shadow[g] = duty_i[g];                    // R7
        d.pend[g]   = 1'b1;
      end
      d.pwm[g] = (d.cnt[g] < d.cmp[g]);
    end

    // Task trigger sources
    d.tmr = '0;
    d.rep = '0;
    case (task_src_i)
      PST_SRC_TIMER: begin
        if (q.tmr >= tmr_period_i - TW'(1)) begin
          fire = 1'b1;
        end else begin
          d.tmr = q.tmr + TW'(1);
        end
      end
      PST_SRC_CARRIER: begin
        d.rep = q.rep;
        if (ev_sel) begin
          if (q.rep + RW'(1) >= task_rep_i) begin
            d.rep = '0;
            fire  = 1'b1;                           // R5 R14
          end else begin
            d.rep = q.rep + RW'(1);
          end
        end
      end
      PST_SRC_EOC: fire = seq_eoc[task_conv_i];     // R3 R10
      default: fire = 1'b0;
    endcase

    // Base task launch and overrun halt
    d.busy = q.busy & ~task_done_i;
    if (fire && !q.ovr) begin
      if (d.busy) begin
        d.ovr = 1'b1;                               // R12
      end else begin
        d.trig = 1'b1;                              // R11
        d.busy = 1'b1;
      end
    end

    // Sticky start overruns, set wins over clear
    for (int c = 0; c < NC; c++) begin
      if (soc_ovr_clr_i[c]) begin
        d.soc_ovr[c] = 1'b0;
      end
      if (seq_ovr[c]) begin
        d.soc_ovr[c] = 1'b1;                        // R17
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign pwm_o       = q.pwm;
  assign uf_o        = q.uf;
  assign ov_o        = q.ov;
  assign eoc_o       = seq_eoc;
  assign soc_ovr_o   = q.soc_ovr;
  assign task_trig_o = q.trig;
  assign task_busy_o = q.busy;
  assign task_ovr_o  = q.ovr;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_uf_at_min: assert property (uf_o[0] |-> q.cnt[0] == CNT_RST) // R13
    else $error("underflow away from counter minimum");
  a_ov_at_max: assert property (
    ov_o[0] |-> q.cnt[0] == $past(carrier_period_i[0])) // R13
    else $error("overflow away from counter maximum");
  a_cmp_on_edge: assert property (
    q.cmp[0] != $past(q.cmp[0]) |-> uf_o[0] || ov_o[0]) // R6
    else $error("compare changed away from an extreme");
  a_write_defer: assert property (
    duty_wr_i[0] |=> q.pend[0] && q.shadow[0] == $past(duty_i[0])) // R7
    else $error("duty write applied at once or lost");
  a_shadow_copy: assert property (
    (q.pend[0] && upd_mask_i[0][EV_OV] && d.ov[0]) |=>
      q.cmp[0] == $past(q.shadow[0])) // R16
    else $error("shadow not copied at selected extreme");
  a_eoc_to_task: assert property (
    (task_src_i == PST_SRC_EOC && seq_eoc[task_conv_i] && !q.ovr &&
     !q.busy) |=> task_trig_o) // R3
    else $error("end of conversion did not trigger task");
  a_rep_cause: assert property (
    (task_trig_o && $past(task_src_i) == PST_SRC_CARRIER) |->
      $past(ev_sel)) // R14
    else $error("carrier task trigger without carrier event");
  a_busy_overrun: assert property (
    (fire && q.busy && !task_done_i) |=> task_ovr_o && !task_trig_o) // R12
    else $error("trigger during busy task not flagged");
  a_ovr_halts: assert property (task_ovr_o |=> task_ovr_o && !task_trig_o) // R12
    else $error("task overrun did not halt triggering");
  a_soc_sticky: assert property (
    (soc_ovr_o[0] && !seq_ovr[0] && !soc_ovr_clr_i[0]) |=> soc_ovr_o[0]) // R17
    else $error("start overrun flag dropped without clear");

endmodule : pst_trig_top

// ### verif/pst_analog_model.sv
/*
 * Analog side model: answers each converter's four-phase request.
 * Assumes requests change just after rising edges of clk_i.
 */
module pst_analog_model
  import pst_pkg::*;
#(
  parameter int NC = NCONV
) (
  input  wire logic                  clk_i,
  input  wire logic                  nrst_i,
  input  wire logic                  slow_i,
  input  wire logic [DW-1:0]         seed_i,
  input  wire pst_smp_req_t [NC-1:0] req_i,
  output pst_smp_rsp_t [NC-1:0]      rsp_o
);
  timeunit 1ns;
  timeprecision 1ps;

  int wait_q [NC];
  int lim;

  // Follows req after a delay; released data changes every cycle
  always @(posedge clk_i or negedge nrst_i) begin
    lim = slow_i ? 9 : 1;
    for (int c = 0; c < NC; c++) begin
      if (!nrst_i) begin
        rsp_o[c] <= '0;
        wait_q[c] = 0;
      end else if (req_i[c].req != rsp_o[c].done && wait_q[c] >= lim) begin
        rsp_o[c].done <= req_i[c].req;
        rsp_o[c].data <= req_i[c].req ? seed_i ^ DW'(req_i[c].chan)
                                      : ~rsp_o[c].data;
        wait_q[c] = 0;
      end else begin
        wait_q[c] = (req_i[c].req != rsp_o[c].done) ? wait_q[c] + 1 : 0;
        if (!rsp_o[c].done)
          rsp_o[c].data <= ~rsp_o[c].data;
      end
    end
  end
endmodule // pst_analog_model

// ### verif/pst_trig_top_test.sv
/*
 * Self-checking bench of pst_trig_top: per-cycle carrier and duty model,
 * conversion order and results, task trigger spacing and overrun.
 * Assumes pst_analog_model on the analog side and two carriers.
 */
module pst_trig_top_test
  import pst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int P = 32;  // Carrier top count
  logic                         clk_i, nrst_i, slow, hold_done, rnd_wr;
  logic                         live, eoc_chk, task_done_i;
  logic [NGEN-1:0][CW-1:0]      carrier_period_i, duty_i;
  logic [NGEN-1:0][1:0]         upd_mask_i;
  logic [NGEN-1:0]              duty_wr_i, pwm_o, uf_o, ov_o;
  pst_conv_cfg_t [NCONV-1:0]    conv_cfg_i;
  pst_smp_rsp_t [NCONV-1:0]     smp_rsp_i;
  pst_smp_req_t [NCONV-1:0]     smp_req_o;
  logic [NCONV-1:0][NCH*DW-1:0] result_o;
  logic [NCONV-1:0]             soc_ovr_clr_i, eoc_o, soc_ovr_o;
  logic [NCONV-1:0]             eoc_p, req_p;
  pst_src_t                     task_src_i;
  logic [GSW-1:0]               task_gen_i;
  logic [1:0]                   task_edges_i;
  logic [RW-1:0]                task_rep_i;
  logic [CSW-1:0]               task_conv_i;
  logic [TW-1:0]                tmr_period_i;
  logic [DW-1:0]                seed;
  logic                         task_trig_o, task_busy_o, task_ovr_o;
  int bad_count, n_compared, cyc, dly, i;
  int cnt_m [NGEN], up_m [NGEN], cmp_m [NGEN], shd_m [NGEN], pend_m [NGEN];
  int idx [NCONV], n_eoc [NCONV];
  int trig_q [$];

  pst_trig_top #(.NG(NGEN), .NC(NCONV)) u_pst_trig_top (
    .clk_i, .nrst_i, .carrier_period_i, .upd_mask_i, .duty_wr_i, .duty_i,
    .conv_cfg_i, .smp_rsp_i, .soc_ovr_clr_i, .task_src_i, .task_gen_i,
    .task_edges_i, .task_rep_i, .task_conv_i, .tmr_period_i, .task_done_i,
    .pwm_o, .uf_o, .ov_o, .smp_req_o, .result_o, .eoc_o, .soc_ovr_o,
    .task_trig_o, .task_busy_o, .task_ovr_o
  );

  pst_analog_model #(.NC(NCONV)) u_pst_analog_model (
    .clk_i, .nrst_i, .slow_i(slow), .seed_i(seed), .req_i(smp_req_o),
    .rsp_o(smp_rsp_i)
  );

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Counts: %0d compared, %0d mismatched", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Checks the spacing of task triggers in cycles
  task automatic spacing(input int exp);
    trig_q.delete();
    for (int k = 0; k < 2000 && trig_q.size() < 4; k++) @(posedge clk_i);
    chk(trig_q.size(), 4);
    if (trig_q.size() < 4) wrap_up();
    chk(trig_q[2] - trig_q[1], exp);
    chk(trig_q[3] - trig_q[2], exp);
  endtask

  // --------------------------------------------------------------------
  // Reference model
  // --------------------------------------------------------------------
  // Carrier count, shadow and active compare per carrier
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      live = 1'b0;
      cnt_m = '{default: 0};
      up_m = '{default: 1};
      cmp_m = '{default: 0};
      pend_m = '{default: 0};
      idx = '{default: 0};
      req_p = '0;
      eoc_p = '0;
    end else begin
      live = 1'b1;
      cyc++;
      for (int g = 0; g < NGEN; g++) begin
        cnt_m[g] = up_m[g] ? cnt_m[g] + 1 : cnt_m[g] - 1;
        if (cnt_m[g] == P)
          up_m[g] = 0;
        if (cnt_m[g] == 0)
          up_m[g] = 1;
        if (pend_m[g] && ((cnt_m[g] == 0 && upd_mask_i[g][EV_UF]) ||
            (cnt_m[g] == P && upd_mask_i[g][EV_OV]))) begin
          cmp_m[g] = shd_m[g];
          pend_m[g] = 0;
        end
        if (duty_wr_i[g]) begin
          shd_m[g] = duty_i[g];
          pend_m[g] = 1;
        end
      end
    end
  end

  // Compares the design with the model between edges
  always @(negedge clk_i) begin
    if (live) begin
      for (int g = 0; g < NGEN; g++) begin
        chk(uf_o[g], cnt_m[g] == 0);
        chk(ov_o[g], cnt_m[g] == P);
        chk(pwm_o[g], cnt_m[g] < cmp_m[g]);
      end
      for (int c = 0; c < NCONV; c++) begin
        if (smp_req_o[c].req && !req_p[c]) begin
          chk(smp_req_o[c].chan,
              conv_cfg_i[c].list[CHW*idx[c] +: CHW]);
          idx[c]++;
        end
        if (eoc_o[c]) begin
          chk(idx[c], conv_cfg_i[c].n_chans);
          for (int k = 0; k < idx[c]; k++)
            chk(result_o[c][DW*k +: DW],
                seed ^ DW'(conv_cfg_i[c].list[CHW*k +: CHW]));
          idx[c] = 0;
          n_eoc[c]++;
        end
        req_p[c] = smp_req_o[c].req;
      end
      if (eoc_chk)
        chk(task_trig_o, eoc_p[task_conv_i]);
      if (task_trig_o === 1'b1)
        trig_q.push_back(cyc);
      eoc_p = eoc_o;
    end
  end

  // Controller: unless hold_done is set, ends each task after three cycles and writes duty in that same cycle
  always @(posedge clk_i) begin
    task_done_i <= 1'b0;
    duty_wr_i <= '0;
    if (task_trig_o === 1'b1 && !hold_done && dly == 0)
      dly = 3;
    if (dly == 1 || (rnd_wr && $urandom_range(3) == 0)) begin
      duty_wr_i <= (dly == 1) ? '1 : NGEN'($urandom);
      duty_i[0] <= CW'($urandom_range(P + 1));
      duty_i[1] <= CW'($urandom_range(P + 1));
    end
    if (dly == 1)
      task_done_i <= 1'b1;
    if (dly > 0)
      dly--;
  end

  // --------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Hang guard
  initial begin
    repeat (30000) @(posedge clk_i);
    bad_count++;
    wrap_up();
  end

  initial begin
    void'($urandom(21260));
    {nrst_i, slow, hold_done, rnd_wr, eoc_chk, task_done_i} = '0;
    carrier_period_i = {CW'(P), CW'(P)};
    upd_mask_i = '1;
    duty_wr_i = '0;
    duty_i = '0;
    conv_cfg_i = '0;
    soc_ovr_clr_i = '0;
    task_src_i = pst_src_t'(2'h3);
    {task_gen_i, task_edges_i, task_rep_i, task_conv_i} = '0;
    tmr_period_i = 16'h000D;
    seed = DW'($urandom);
    {dly, cyc, bad_count, n_compared} = '0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    rnd_wr <= 1'b1;
    for (int m = 1; m < 4; m++) begin
      upd_mask_i <= {2'(m), 2'(m)};
      repeat (150) @(posedge clk_i);
    end
    rnd_wr <= 1'b0;
    $display("Test duty shadow done");
    task_src_i <= PST_SRC_TIMER;
    spacing(13);
    $display("Test timer trigger done");
    task_src_i <= PST_SRC_CARRIER;
    for (int t = 0; t < 4; t++) begin
      task_gen_i <= GSW'(t);
      task_edges_i <= 2'(t % 3 + 1);
      task_rep_i <= RW'(t);
      spacing((t == 0 ? 1 : t) * (t % 3 == 2 ? P : 2 * P));
    end
    $display("Test carrier trigger done");
    for (int c = 0; c < NCONV; c++) begin
      conv_cfg_i[c].gen <= GSW'(c);
      conv_cfg_i[c].edges <= c ? 2'b01 : 2'b10;
      conv_cfg_i[c].n_chans <= NW'(3 + c);
      conv_cfg_i[c].list <= (NCH*CHW)'($urandom);
    end
    upd_mask_i <= {2'b10, 2'b10};
    task_src_i <= PST_SRC_EOC;
    task_conv_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    eoc_chk <= 1'b1;
    repeat (400) @(posedge clk_i);
    chk(n_eoc[0] > 3 && n_eoc[1] > 3, 1'b1);
    $display("Test phase-shifted conversion done");
    slow <= 1'b1;
    for (i = 0; i < 1000 && soc_ovr_o !== 2'b11; i++) @(posedge clk_i);
    chk(soc_ovr_o, 2'b11);
    if (soc_ovr_o !== 2'b11) wrap_up();
    conv_cfg_i[0].edges <= '0;
    conv_cfg_i[1].edges <= '0;
    repeat (300) @(posedge clk_i);
    soc_ovr_clr_i <= '1;
    @(posedge clk_i);
    soc_ovr_clr_i <= '0;
    repeat (3) @(posedge clk_i);
    chk(soc_ovr_o, 2'b00);
    $display("Test start overrun done");
    eoc_chk <= 1'b0;
    hold_done <= 1'b1;
    task_src_i <= PST_SRC_TIMER;
    for (i = 0; i < 100 && task_ovr_o !== 1'b1; i++) @(posedge clk_i);
    chk(task_ovr_o, 1'b1);
    if (task_ovr_o !== 1'b1) wrap_up();
    trig_q.delete();
    repeat (60) @(posedge clk_i);
    chk(trig_q.size(), 0);
    chk(task_busy_o, 1'b1);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({task_ovr_o, task_busy_o, soc_ovr_o, eoc_o, uf_o, ov_o}, '0);
    nrst_i <= 1'b1;
    hold_done <= 1'b0;
    repeat (100) @(posedge clk_i);
    $display("Test task overrun and reset done");
    wrap_up();
  end
endmodule // pst_trig_top_test
